// File: pga_link_pkg.sv
// Shared constants for the amplifier serial command port and its controller.
// Assumes both ends run on one system clock; the link clock is sampled.
package pga_link_pkg;
  localparam int WORD_BITS  = 16;
  localparam int CNT_W      = 5;
  localparam logic [CNT_W-1:0] WORD_LAST = 5'h0F;
  localparam int CMD_HI     = 15;
  localparam int CMD_LO     = 13;
  localparam int TARGET_BIT = 8;
  localparam int CODE_HI    = 2;
  localparam int CODE_LO    = 0;
  localparam logic [2:0] CMD_NOOP     = 3'h0;
  localparam logic [2:0] CMD_SHUTDOWN = 3'h1;
  localparam logic [2:0] CMD_WRITE    = 3'h2;
  localparam logic [2:0] CODE_RESET   = 3'h0;
  localparam logic [7:0] INSTR_RESET  = 8'h00;
  // Controller register map, word addresses on Avalon-MM
  localparam logic [1:0] ADDR_DATA    = 2'h0;
  localparam logic [1:0] ADDR_CTRL    = 2'h1;
  localparam logic [1:0] ADDR_STATUS  = 2'h2;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_LEN_LO   = 8;
  localparam int LEN_W         = 4;
  localparam int HALF_DIV      = 4;
  localparam logic [31:0] UNMAPPED_READ = 32'h0;
  typedef enum {M_IDLE, M_SETUP, M_LOW, M_HIGH, M_DONE} master_state_t;
endpackage : pga_link_pkg

// File: pga_link_if.sv
// Four-wire serial link between controller and amplifier command port.
// Assumes the bench wires this once; single driver per wire.
`timescale 1ns/10ps
interface pga_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  modport device (input sck, input cs_n, input si, output so);
  modport host   (output sck, output cs_n, output si, input so);
endinterface : pga_link_if

// File: pga_serial_command_port.sv
// Amplifier serial command port: shift register, decode, gain/input state.
// Assumes SCK, CS and SI come asynchronously from a controller; all are
// resampled on CLK_SYS, so SCK must be slower than a quarter of CLK_SYS.
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
// Notes on behaviour
// - Commands are whole 16-bit words under select
// - First byte is instruction, steering second byte
// - Sample SI on rise, drive SO on fall
// - Power-up: no-op, gain one, input zero
// - Command 000 no-op, 001 shutdown, 010 write
// - Controller sends only 000 as no-op
// - Shutdown only after full word and select rise
// - Target bit one selects input, zero gain
// - No-op and shutdown ignore all other bits
// - Valid write wakes device; shutdown never toggles
// - Gain code three bits, upper bits ignored
// - Input code mapped per variant channel count
// - Gain and input survive shutdown
// - Controller may rewrite current value to wake
// - Chain: output feeds next input, shared lines
// - Non-multiple of 16 clocks aborts command
// - Select rise executes and clears shift register
// - Short strings leave far devices a no-op
// - Output low while deselected, never floating
// - Reset restores instruction, gain, input defaults
// - Shutdown forced while reset is active
module pga_serial_command_port
  import pga_link_pkg::*;
#(
  parameter int INPUTS = 8
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RST_B,
  pga_link_if.device      LINK,
  output logic [2:0]      GAIN_CODE,
  output logic [2:0]      INPUT_CODE,
  output logic [7:0]      INSTRUCTION,
  output logic            SHUTDOWN
);
  import pga_link_pkg::*;

  // Lane order in the sampling chain; idle levels keep edges quiet
  localparam int               LANES     = 3;
  localparam int               LANE_SCK  = 0;
  localparam int               LANE_CS   = 1;
  localparam int               LANE_SI   = 2;
  localparam logic [LANES-1:0] LANE_IDLE = 3'h2;
  localparam int               BYTE_LO   = WORD_BITS / 2;

  // Limitation: every link wire costs two to three system clocks of lag,
  // so a link half period must be several system clocks long. The trade
  // is a fully synchronous port with no logic on the link clock itself.

  logic [LANES-1:0]     pin_raw;
  logic [LANES-1:0]     pin_sync;
  logic [LANES-1:0]     pin_old;
  logic [WORD_BITS-1:0] shreg;
  logic [WORD_BITS-1:0] next_shreg;
  logic [CNT_W-1:0]     bits;
  logic [CNT_W-1:0]     next_bits;
  logic                 seen;
  logic                 so_q;
  logic                 next_so;
  logic                 sleep;
  logic                 next_sleep;
  logic [7:0]           next_instr;
  logic [2:0]           next_gain;
  logic [2:0]           next_input;

  // Input mapping per variant channel count; other counts act as eight
  function automatic logic [2:0] map_input(input logic [2:0] c);
    case (INPUTS)
      1:       map_input = 3'h0;
      2:       map_input = {2'h0, c[0]};
      6:       map_input = (c[2:1] == 2'h3) ? 3'h0 : c;
      default: map_input = c;
    endcase
  endfunction : map_input

  // Command field match, shared by the write and shutdown decodes
  function automatic logic cmd_is(input logic [WORD_BITS-1:0] w,
                                  input logic [2:0]           op);
    cmd_is = (w[CMD_HI:CMD_LO] == op);
  endfunction : cmd_is

  // Raw link wires in lane order
  assign pin_raw[LANE_SCK] = LINK.sck;
  assign pin_raw[LANE_CS]  = LINK.cs_n;
  assign pin_raw[LANE_SI]  = LINK.si;

  // Two flops per link wire before any logic reads it; the third flop
  // only feeds the edge detectors. Reset loads the idle level of each
  // wire so that no false edge follows reset.
  for (genvar g = 0; g < LANES; g++) begin : g_sync
    logic meta;
    logic sync;
    logic old;
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
        meta <= LANE_IDLE[g];
        sync <= LANE_IDLE[g];
        old  <= LANE_IDLE[g];
      end else begin
        meta <= pin_raw[g];
        sync <= meta;
        old  <= sync;
      end
    end
    assign pin_sync[g] = sync;
    assign pin_old[g]  = old;
  end

  // Edge and level decode of the sampled wires
  wire sck_rise = pin_sync[LANE_SCK] & ~pin_old[LANE_SCK];
  wire sck_fall = ~pin_sync[LANE_SCK] & pin_old[LANE_SCK];
  wire cs_fall  = ~pin_sync[LANE_CS] & pin_old[LANE_CS];
  wire cs_rise  = pin_sync[LANE_CS] & ~pin_old[LANE_CS];
  wire selected = ~pin_sync[LANE_CS];
  wire si_bit   = pin_sync[LANE_SI];

  // Whole words only: counter wraps each 16 bits, zero means aligned
  wire whole    = (bits == '0);
  wire is_write = cmd_is(shreg, CMD_WRITE);
  wire is_sleep = cmd_is(shreg, CMD_SHUTDOWN);
  wire to_input = shreg[TARGET_BIT];
  wire [2:0] code = shreg[CODE_HI:CODE_LO];
  wire shift_en = selected & sck_rise;
  // A select rise with no clock at all carries no command
  wire execute  = cs_rise & whole & seen;

  // Shift path: MSB first; last word in the register wins
  assign next_shreg = {shreg[WORD_BITS-2:0], si_bit};
  assign next_bits  = (bits == WORD_LAST) ? '0 : bits + 1'b1;

  // SO carries the word shifted in one word earlier; low when deselected
  assign next_so = selected & shreg[WORD_BITS-1];
  wire   so_load = ~selected | cs_fall | sck_fall;

  // Execute decode; no-op and shutdown leave both codes alone, and the
  // codes are never cleared by shutdown so a wake restores them as held
  assign next_instr = shreg[WORD_BITS-1:BYTE_LO];
  assign next_gain  = (is_write & ~to_input) ? code : GAIN_CODE;
  assign next_input = (is_write & to_input) ? map_input(code)
                                            : INPUT_CODE;
  // Repeated shutdown stays asleep; only a write wakes
  assign next_sleep = is_sleep | (sleep & ~is_write);

  // Shift in on rising SCK; cleared when select rises
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      shreg <= '0;
      bits  <= '0;
      seen  <= 1'b0;
    end else if (cs_rise) begin
      shreg <= '0;
      bits  <= '0;
      seen  <= 1'b0;
    end else if (shift_en) begin
      shreg <= next_shreg;
      bits  <= next_bits;
      seen  <= 1'b1;
    end
  end

  // SO register: moves on select fall, each falling SCK and deselect
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      so_q <= 1'b0;
    end else if (so_load) begin
      so_q <= next_so;
    end
  end
  assign LINK.so = so_q;

  // Execute on select rise; an aborted frame changes nothing
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      INSTRUCTION <= INSTR_RESET;
      GAIN_CODE   <= CODE_RESET;
      INPUT_CODE  <= CODE_RESET;
      sleep       <= 1'b0;
    end else if (execute) begin
      INSTRUCTION <= next_instr;
      GAIN_CODE   <= next_gain;
      INPUT_CODE  <= next_input;
      sleep       <= next_sleep;
    end
  end

  // Reset holds shutdown whatever software state says
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      SHUTDOWN <= 1'b1;
    end else begin
      SHUTDOWN <= sleep;
    end
  end
endmodule : pga_serial_command_port

// File: pga_link_controller.sv
// Controller end: Avalon-MM registers drive word transfers on the link.
// Assumes software writes a word then starts a frame of N words.
`timescale 1ns/10ps
module pga_link_controller
  import pga_link_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_B,
  pga_link_if.host         LINK,
  input  wire logic [1:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  output logic [31:0]      READDATA,
  output logic             WAITREQUEST
);
  import pga_link_pkg::*;

  master_state_t        state;
  logic [WORD_BITS-1:0] tx;
  logic [WORD_BITS-1:0] rx;
  logic [CNT_W-1:0]     bitn;
  logic [LEN_W-1:0]     words;
  logic [LEN_W-1:0]     left;
  logic                 idle_high;
  logic [2:0]           div;
  logic [1:0]           so_s;
  logic                 sck_q;
  logic                 cs_q;
  logic                 ack;

  wire busy     = (state != M_IDLE);
  wire tick     = (div == 3'(HALF_DIV - 1));
  // Writes land only at the edge that shows waitrequest low
  wire next_ack = (READ | WRITE) & ~ack;
  wire wr_data  = WRITE & ack & (ADDRESS == ADDR_DATA) & ~busy;
  wire wr_ctrl  = WRITE & ack & (ADDRESS == ADDR_CTRL) & ~busy;
  wire start    = wr_ctrl & (WRITEDATA[CTRL_LEN_LO +: LEN_W] != '0);
  wire last_bit = (bitn == WORD_LAST);
  wire [31:0] rd_mux =
    (ADDRESS == ADDR_DATA)   ? {16'h0, rx} :
    (ADDRESS == ADDR_CTRL)   ? {20'h0, words, 7'h0, idle_high} :
    (ADDRESS == ADDR_STATUS) ? {31'h0, busy} : UNMAPPED_READ;

  // One wait cycle per access; answer on second edge
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      ack         <= 1'b0;
      WAITREQUEST <= 1'b1;
      READDATA    <= '0;
    end else begin
      ack         <= next_ack;
      WAITREQUEST <= ~next_ack;
      READDATA    <= rd_mux;
    end
  end

  // Sample SO through two flops
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      so_s <= '0;
    end else begin
      so_s <= {so_s[0], LINK.so};
    end
  end

  // Frame sequencer: whole 16-bit words only, MSB first
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      state <= M_IDLE;
      div <= '0;
      bitn <= '0;
      left <= '0;
      words <= 4'h1;
      idle_high <= 1'b0;
      tx <= '0;
      rx <= '0;
      sck_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      div <= (busy && !tick) ? div + 3'h1 : 3'h0;
      if (wr_data) tx <= WRITEDATA[WORD_BITS-1:0];
      if (wr_ctrl) begin
        idle_high <= WRITEDATA[CTRL_MODE_BIT];
        words <= WRITEDATA[CTRL_LEN_LO +: LEN_W];
        sck_q <= WRITEDATA[CTRL_MODE_BIT];
      end
      case (state)
        M_IDLE: if (start) begin
          state <= M_SETUP;
          left  <= WRITEDATA[CTRL_LEN_LO +: LEN_W];
          bitn  <= '0;
        end
        // Select falls first; SCK drops a half period later, never together
        M_SETUP: if (tick) begin
          if (cs_q) begin
            cs_q  <= 1'b0;
          end else begin
            sck_q <= 1'b0;
            state <= M_LOW;
          end
        end
        M_LOW: if (tick) begin
          sck_q <= 1'b1;
          state <= M_HIGH;
        end
        // SO is sampled late in the high half: its path lags five clocks
        M_HIGH: if (tick) begin
          sck_q <= 1'b0;
          rx    <= {rx[WORD_BITS-2:0], so_s[1]};
          bitn  <= last_bit ? '0 : bitn + 1'b1;
          tx    <= {tx[WORD_BITS-2:0], tx[WORD_BITS-1]};
          if (last_bit && left == 4'h1) begin
            sck_q <= idle_high;
            state <= M_DONE;
          end else begin
            if (last_bit) left <= left - 1'b1;
            state <= M_LOW;
          end
        end
        M_DONE: if (tick) begin
          cs_q  <= 1'b1;
          state <= M_IDLE;
        end
        default: state <= M_IDLE;
      endcase
    end
  end

  assign LINK.sck  = sck_q;
  assign LINK.cs_n = cs_q;
  assign LINK.si   = tx[WORD_BITS-1];
endmodule : pga_link_controller

// File: pga_link_asserts.sv
// Wire checks for the serial link between controller and command port.
// Assumes one controller and one command port share this link.
`timescale 1ns/10ps
module pga_link_asserts (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so
);
  logic        sck_d;
  logic [5:0]  rises;
  logic [15:0] hist;
  // Sampling edge seen inside a frame
  wire         rise_in = sck && !sck_d && !cs_n;

  // Count edges and keep sent bits; cleared like the port's register
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      sck_d <= 1'b0;
      rises <= 6'h00;
      hist  <= 16'h0000;
    end else begin
      sck_d <= sck;
      if (cs_n) begin
        rises <= 6'h00;
        hist  <= 16'h0000;
      end else if (rise_in) begin
        rises <= rises + 6'h01;
        hist  <= {hist[14:0], si};
      end
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  a_so_idle_low: assert property (cs_n [*8] |-> !so)
    else $error("so not low while deselected");
  a_sck_cs_quiet: assert property ($fell(cs_n) |-> $stable(sck))
    else $error("sck moved with select edge");
  a_half_period: assert property ($changed(sck) && !cs_n |=> $stable(sck) [*3])
    else $error("sck half period short");
  a_frame_hold: assert property ($fell(cs_n) |-> !cs_n [*8])
    else $error("select released too soon");
  a_si_hold: assert property (rise_in |=> $stable(si) [*2])
    else $error("si moved after sampling edge");
  a_whole_words: assert property ($rose(cs_n) |-> rises[3:0] == 4'h0 && rises != 6'h00)
    else $error("frame not whole words");
  a_zero_lead: assert property (rise_in && rises < 6'd16 |-> !so)
    else $error("first word out not zero");
  a_shift_thru: assert property (rise_in && rises >= 6'd16 |-> so == hist[15])
    else $error("so not si delayed by a word");

  c_two_words: cover property (rise_in && rises == 6'd31);
  c_idle_high: cover property ($fell(cs_n) && sck);
  c_one_word: cover property ($rose(cs_n) && rises == 6'd16);
endmodule : pga_link_asserts

// File: pga_serial_command_port_tb.sv
// Bench: controller drives the command port; a second port is bit-banged.
// Assumes the package register map and a 4-clock link half period.
`timescale 1ns/10ps
module pga_serial_command_port_tb;
  import pga_link_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic [1:0]  address = 2'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd;
  logic        waitrequest, shutdown, shutdown_2;
  logic [2:0]  gain_code, input_code, gain_code_2, input_code_2;
  logic [7:0]  instruction, instruction_2;
  logic [2:0]  cmds [14] = '{2, 1, 1, 2, 0, 2, 1, 0, 2, 0, 2, 1, 0, 2};
  int          error_cnt = 0, comparisons = 0, cycles = 0;
  int          gain = 0, inp = 0, sd = 1, instr = 0;
  pga_link_if link ();
  pga_link_if link_2 ();

  pga_link_controller i_pga_link_controller (.CLK_SYS(clk_sys),
    .RST_B(rst_b), .LINK(link), .ADDRESS(address), .READ(read),
    .WRITE(write), .WRITEDATA(writedata), .READDATA(readdata),
    .WAITREQUEST(waitrequest));
  pga_serial_command_port i_pga_serial_command_port (.CLK_SYS(clk_sys),
    .RST_B(rst_b), .LINK(link), .GAIN_CODE(gain_code),
    .INPUT_CODE(input_code), .INSTRUCTION(instruction),
    .SHUTDOWN(shutdown));
  pga_serial_command_port #(.INPUTS(6)) i_pga_serial_command_port_2 (
    .CLK_SYS(clk_sys), .RST_B(rst_b), .LINK(link_2),
    .GAIN_CODE(gain_code_2), .INPUT_CODE(input_code_2),
    .INSTRUCTION(instruction_2), .SHUTDOWN(shutdown_2));
  pga_link_asserts u_asserts (.CLK_SYS(clk_sys), .RST_B(rst_b),
    .sck(link.sck), .cs_n(link.cs_n), .si(link.si), .so(link.so));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic chk_state;
    chk(gain_code, gain);
    chk(input_code, inp);
    chk(shutdown, sd);
    chk(instruction, instr);
  endtask : chk_state

  // Avalon cycle: request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [1:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus

  // One frame of n copies of w, then model update and compare
  task automatic frame(input logic [15:0] w, input int mode, input int n);
    bus(1'b1, ADDR_DATA, {16'h0, w});
    bus(1'b1, ADDR_CTRL, (n << CTRL_LEN_LO) | mode);
    do bus(1'b0, ADDR_STATUS, 32'h0); while (rd[0] === 1'b1);
    repeat (8) @(posedge clk_sys);
    if (w[15:13] == CMD_WRITE) begin
      if (w[TARGET_BIT]) inp = w[2:0];
      else gain = w[2:0];
      sd = 0;
    end
    if (w[15:13] == CMD_SHUTDOWN) sd = 1;
    instr = w[15:8];
    chk_state;
    bus(1'b0, ADDR_DATA, 32'h0);
    chk(rd[15:0], n > 1 ? w : 16'h0);
  endtask : frame

  // Bit-banged frame of nb bits, MSB first, on the second link
  task automatic bang(input logic [31:0] w, input int nb);
    for (int i = nb - 1; i >= 0; i--) begin
      link_2.cs_n <= 1'b0;
      link_2.si <= w[i];
      link_2.sck <= 1'b0;
      repeat (4) @(posedge clk_sys);
      link_2.sck <= 1'b1;
      repeat (4) @(posedge clk_sys);
    end
    link_2.sck <= 1'b0;
    repeat (4) @(posedge clk_sys);
    link_2.cs_n <= 1'b1;
    link_2.si <= ~link_2.si;
    repeat (8) @(posedge clk_sys);
  endtask : bang

  task automatic final_report;
    $display("COUNTS comparisons=%0d errors=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // Hang guard well above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      final_report;
    end
  end

  initial begin
    logic [15:0] w;
    link_2.sck = 1'b0;
    link_2.cs_n = 1'b1;
    link_2.si = 1'b0;
    void'($urandom(19));
    repeat (4) @(posedge clk_sys);
    chk_state;
    rst_b <= 1'b1;
    sd = 0;
    repeat (2) @(posedge clk_sys);
    chk_state;
    bus(1'b0, 2'h3, 32'h0);
    chk(rd, UNMAPPED_READ);
    $display("TEST reset and map done");
    for (int i = 0; i < 14; i++) begin
      w = $urandom;
      w[15:13] = cmds[i];
      frame(w, $urandom_range(1, 0), $urandom_range(2, 1));
    end
    frame(16'h2000, 0, 1);
    frame({8'h40, 5'h0, 3'(gain)}, 1, 1);
    $display("TEST command decode done");
    bang(32'h4005, 16);
    chk(gain_code_2, 3'h5);
    bang(32'h4203, 15);
    bang({15'h0, 16'h4003, 1'b1}, 17);
    chk(gain_code_2, 3'h5);
    chk(instruction_2, 8'h40);
    bang({16'h4107, 16'h4106}, 32);
    chk(input_code_2, 3'h0);
    bang(32'h4105, 16);
    chk(input_code_2, 3'h5);
    $display("TEST broken frames done");
    rst_b <= 1'b0;
    {gain, inp, sd, instr} = {32'd0, 32'd0, 32'd1, 32'd0};
    repeat (2) @(posedge clk_sys);
    chk_state;
    rst_b <= 1'b1;
    sd = 0;
    repeat (2) @(posedge clk_sys);
    chk_state;
    frame(16'h4003, 1, 1);
    $display("TEST mid-run reset done");
    final_report;
  end
endmodule : pga_serial_command_port_tb
